// file: logic/scp_sdram_dev.sv
// SDRAM device end: four banks with concurrent auto precharge.
// Functional notes
// - Read interrupts AP write; data after latency.
// - Interrupted write precharges after recovery time.
// - Last interrupted write word precedes read.
// - Write to other bank ends AP burst.
// - Write-interrupt precharge waits recovery from command.
// - New write edge data belongs new bank.
// - Chip select high means no operation.
// - Mode load may precede refresh cycles.
// - Column commands ignore address bits 8,9,11.
// - Controller keeps row-active time before explicit precharge, not before auto precharge.
// - Auto precharge closes row after burst.
// - Precharged bank needs activate before access.
module scp_sdram_dev #(
  parameter int ROW_KEEP = 4
) (
  // Clock and control
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Memory pins
  scp_if.dev pins,
  // Status
  output logic [scp_pkg::NUM_BANKS-1:0] o_bank_open,
  output logic [scp_pkg::NUM_BANKS-1:0] o_ap_pending
);
  localparam int NB = scp_pkg::NUM_BANKS;
  localparam int CW = scp_pkg::COL_W;
  localparam int DW = scp_pkg::DQ_W;
  localparam int IW = scp_pkg::BANK_W + ROW_KEEP + CW;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [8:0] bl_len(logic [2:0] code);
    logic [8:0] n;
    n = 9'h001;
    if (code == scp_pkg::BL_CODE_FULL) n = 9'(scp_pkg::BL_FULL);
    else if (code < 3'h4) n = 9'h001 << code;
    return n;
  endfunction

  // Column wraps inside the burst-aligned block, as sequential order requires.
  function automatic logic [CW-1:0] col_next(logic [CW-1:0] c, logic [8:0] len);
    logic [CW-1:0] m;
    m = CW'(len - 9'h001);
    return (c & ~m) | (CW'(c + 1'b1) & m);
  endfunction

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [scp_pkg::ADDR_W-1:0] mode_q;
  logic [NB-1:0] open_w;
  logic [NB-1:0] rec_busy_w;
  logic [NB-1:0][scp_pkg::ADDR_W-1:0] row_w;
  logic [DW-1:0] mem_q [2**IW];

  wire logic [2:0] cmd_w = pins.cs_n ? scp_pkg::CMD_NOP
                                     : {pins.ras_n, pins.cas_n, pins.we_n};
  wire logic is_act = (cmd_w == scp_pkg::CMD_ACT);
  wire logic is_rd = (cmd_w == scp_pkg::CMD_RD);
  wire logic is_wr = (cmd_w == scp_pkg::CMD_WR);
  wire logic is_pre = (cmd_w == scp_pkg::CMD_PRE);
  wire logic is_mrs = (cmd_w == scp_pkg::CMD_MRS);
  wire logic [1:0] ba = pins.ba;
  wire logic col_ok = open_w[ba] & ~rec_busy_w[ba];
  wire logic rd_go = is_rd & col_ok;
  wire logic wr_go = is_wr & col_ok;
  wire logic col_go = rd_go | wr_go;
  wire logic [CW-1:0] cmd_col = pins.addr[CW-1:0];
  wire logic cmd_ap = pins.addr[scp_pkg::AP_BIT];
  wire logic [8:0] bl_w = bl_len(mode_q[scp_pkg::MODE_BL_LSB +: 3]);
  wire logic [8:0] wbl_w = mode_q[scp_pkg::MODE_WB_BIT] ? 9'h001 : bl_w;
  wire logic [2:0] cl_w = mode_q[scp_pkg::MODE_CL_LSB +: 3];
  wire logic [1:0] ins_w = 2'(scp_pkg::PIPE_MAX - int'(cl_w));

  // ****************************************************************
  // Write burst engine
  // ****************************************************************
  logic wr_act_q;
  logic wr_ap_q;
  logic [1:0] wr_bank_q;
  logic [CW-1:0] wr_col_q;
  logic [8:0] wr_left_q;

  // Any column command ends a running write; a read drops its own edge data.
  wire logic wr_cont = wr_act_q & ~col_go;
  wire logic wr_en = wr_go | wr_cont;
  wire logic [1:0] wr_bank = wr_go ? ba : wr_bank_q;
  wire logic [CW-1:0] wr_col = wr_go ? cmd_col : wr_col_q;
  wire logic [IW-1:0] wr_idx = {wr_bank, row_w[wr_bank][ROW_KEEP-1:0], wr_col};

  always_ff @(posedge i_ref_clk)
  begin
    if (i_clk_en && wr_en && !pins.dqm)
      mem_q[wr_idx] <= pins.dq;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wr_act_q <= 1'b0;
      wr_ap_q <= 1'b0;
      wr_bank_q <= '0;
      wr_col_q <= '0;
      wr_left_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (wr_go)
      begin
        wr_act_q <= (wbl_w != 9'h001);
        wr_ap_q <= cmd_ap;
        wr_bank_q <= ba;
        wr_col_q <= col_next(cmd_col, wbl_w);
        wr_left_q <= wbl_w - 9'h001;
      end
      else if (wr_cont)
      begin
        wr_act_q <= (wr_left_q != 9'h001);
        wr_col_q <= col_next(wr_col_q, wbl_w);
        wr_left_q <= wr_left_q - 9'h001;
      end
      else if (rd_go)
        wr_act_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read burst engine and latency pipe
  // ****************************************************************
  logic rd_act_q;
  logic rd_ap_q;
  logic [1:0] rd_bank_q;
  logic [CW-1:0] rd_col_q;
  logic [8:0] rd_left_q;
  logic [scp_pkg::PIPE_MAX-1:0] pv_w;
  logic [scp_pkg::PIPE_MAX-1:0][DW-1:0] pd_w;

  wire logic rd_cont = rd_act_q & ~col_go;
  wire logic rd_en = rd_go | rd_cont;
  wire logic [1:0] rd_bank = rd_go ? ba : rd_bank_q;
  wire logic [CW-1:0] rd_col = rd_go ? cmd_col : rd_col_q;
  wire logic [IW-1:0] rd_idx = {rd_bank, row_w[rd_bank][ROW_KEEP-1:0], rd_col};
  wire logic [DW-1:0] rd_word = mem_q[rd_idx];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      rd_act_q <= 1'b0;
      rd_ap_q <= 1'b0;
      rd_bank_q <= '0;
      rd_col_q <= '0;
      rd_left_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (rd_go)
      begin
        rd_act_q <= (bl_w != 9'h001);
        rd_ap_q <= cmd_ap;
        rd_bank_q <= ba;
        rd_col_q <= col_next(cmd_col, bl_w);
        rd_left_q <= bl_w - 9'h001;
      end
      else if (rd_cont)
      begin
        rd_act_q <= (rd_left_q != 9'h001);
        rd_col_q <= col_next(rd_col_q, bl_w);
        rd_left_q <= rd_left_q - 9'h001;
      end
      else if (wr_go)
        rd_act_q <= 1'b0;
    end
  end

  // A word enters the pipe at the stage that leaves exactly the read latency.
  for (genvar i = 0; i < scp_pkg::PIPE_MAX; i++)
  begin : g_pipe
    logic v_q;
    logic [DW-1:0] d_q;
    logic pv;
    logic [DW-1:0] pd;
    if (i == 0)
    begin : g_head
      assign pv = 1'b0;
      assign pd = '0;
    end
    else
    begin : g_tail
      assign pv = pv_w[i-1];
      assign pd = pd_w[i-1];
    end
    always_ff @(posedge i_ref_clk)
    begin
      if (i_sys_rst)
      begin
        v_q <= 1'b0;
        d_q <= '0;
      end
      else if (i_clk_en)
      begin
        v_q <= (ins_w == 2'(i)) ? rd_en : pv;
        d_q <= (ins_w == 2'(i)) ? rd_word : pd;
      end
    end
    assign pv_w[i] = v_q;
    assign pd_w[i] = d_q;
  end

  assign pins.dev_dq_o = pd_w[scp_pkg::PIPE_MAX-1];
  assign pins.dev_dq_oe = pv_w[scp_pkg::PIPE_MAX-1];

  // ****************************************************************
  // Per-bank row state and precharge timers
  // ****************************************************************
  for (genvar b = 0; b < NB; b++)
  begin : g_bank
    logic open_q;
    logic [scp_pkg::ADDR_W-1:0] row_q;
    logic [3:0] rec_q;
    logic [3:0] pre_q;
    // An ending or interrupted AP write starts its recovery on this edge.
    wire logic rec_start = (wr_act_q & wr_ap_q & (wr_bank_q == 2'(b))
                            & (col_go | (wr_left_q == 9'h001)))
                           | (wr_go & cmd_ap & (wbl_w == 9'h001) & (ba == 2'(b)));
    wire logic rd_close = (rd_act_q & rd_ap_q & (rd_bank_q == 2'(b))
                           & (col_go | (rd_left_q == 9'h001)))
                          | (rd_go & cmd_ap & (bl_w == 9'h001) & (ba == 2'(b)));
    wire logic cmd_pre = is_pre & (pins.addr[scp_pkg::AP_BIT] | (ba == 2'(b)))
                         & (rec_q == 4'h0);
    wire logic pre_go = (rec_q == 4'h1) | rd_close | (cmd_pre & open_q);
    wire logic act_go = is_act & (ba == 2'(b)) & ~open_q
                        & (rec_q == 4'h0) & (pre_q == 4'h0);

    always_ff @(posedge i_ref_clk)
    begin
      if (i_sys_rst)
      begin
        open_q <= 1'b0;
        row_q <= '0;
        rec_q <= '0;
        pre_q <= '0;
      end
      else if (i_clk_en)
      begin
        if (rec_start)
          rec_q <= 4'(scp_pkg::WR_CYC);
        else if (rec_q != 4'h0)
          rec_q <= rec_q - 4'h1;
        if (pre_go)
        begin
          open_q <= 1'b0;
          pre_q <= 4'(scp_pkg::RP_CYC);
        end
        else
        begin
          if (pre_q != 4'h0)
            pre_q <= pre_q - 4'h1;
          if (act_go)
          begin
            open_q <= 1'b1;
            row_q <= pins.addr;
          end
        end
      end
    end
    assign open_w[b] = open_q;
    assign rec_busy_w[b] = (rec_q != 4'h0);
    assign row_w[b] = row_q;
  end

  // ****************************************************************
  // Mode word and status
  // ****************************************************************
  // Refresh needs no prior mode load, so either initial order works.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      mode_q <= scp_pkg::MODE_RST;
      o_bank_open <= '0;
      o_ap_pending <= '0;
    end
    else if (i_clk_en)
    begin
      if (is_mrs && (open_w == '0))
        mode_q <= pins.addr;
      o_bank_open <= open_w;
      o_ap_pending <= rec_busy_w;
    end
  end
endmodule

// file: logic/scp_pkg.sv
// Shared constants and types for the concurrent auto precharge SDRAM pair.
package scp_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W = 8;
  localparam int DQ_W = 16;
  localparam int PIPE_MAX = 3;
  localparam int AP_BIT = 10;
  localparam int BL_FULL = 256;

  // ****************************************************************
  // Command encodings as {ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ****************************************************************
  // Mode word fields
  // ****************************************************************
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h032;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int T_WR_NS = 10;
  localparam int T_RP_NS = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RAS_NS = 42;
  localparam int T_RFC_NS = 60;
  localparam int T_INIT_US = 100;
  localparam int T_MRD_CYC = 3;

  function automatic int min_cyc(int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WR_CYC = min_cyc(T_WR_NS);
  localparam int RP_CYC = min_cyc(T_RP_NS);
  localparam int RCD_CYC = min_cyc(T_RCD_NS);
  localparam int RAS_CYC = min_cyc(T_RAS_NS);
  localparam int RFC_CYC = min_cyc(T_RFC_NS);
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;

  // ****************************************************************
  // User operations of the controller end
  // ****************************************************************
  typedef enum logic [1:0] {OP_ACT, OP_RD, OP_WR, OP_PRE} scp_op_e;

endpackage

// file: logic/scp_if.sv
// Pin bundle between the SDRAM device end and the controller end.
interface scp_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [scp_pkg::BANK_W-1:0] ba;
  logic [scp_pkg::ADDR_W-1:0] addr;
  logic dqm;
  logic [scp_pkg::DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [scp_pkg::DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [scp_pkg::DQ_W-1:0] dq;

  // Resolved data wire; an undriven bus reads as zero.
  assign dq = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : '0);

  modport dev (
    input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
    output dev_dq_o, dev_dq_oe
  );
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe,
    input dq
  );
endinterface

// file: logic/scp_sdram_ctl.sv
// SDRAM controller end: init sequence, timing guards and data paths.
module scp_sdram_ctl #(
  parameter int INIT_CYC = scp_pkg::INIT_CYC,
  parameter int CAS_LAT = 3,
  parameter int BURST_LEN = 4
) (
  // Clock and control
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Memory pins
  scp_if.ctl pins,
  // User request
  input wire logic i_cmd_valid,
  input wire scp_pkg::scp_op_e i_cmd_op,
  input wire logic [scp_pkg::BANK_W-1:0] i_cmd_bank,
  input wire logic [scp_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic i_cmd_ap,
  input wire logic [scp_pkg::DQ_W-1:0] i_wdata,
  input wire logic i_wmask,
  // User answers
  output logic o_cmd_taken,
  output logic o_wbeat,
  output logic [scp_pkg::DQ_W-1:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_init_done
);
  localparam int NB = scp_pkg::NUM_BANKS;
  localparam logic [scp_pkg::ADDR_W-1:0] MODE_WORD =
    scp_pkg::ADDR_W'((CAS_LAT << scp_pkg::MODE_CL_LSB) | $clog2(BURST_LEN));

  typedef enum logic [2:0] {ST_POWER, ST_PREALL, ST_MODE, ST_REF_A, ST_REF_B, ST_RUN} scp_st_e;

  // ****************************************************************
  // Init sequence
  // ****************************************************************
  scp_st_e st_q, st_d;
  logic [15:0] wt_q, wt_d;
  logic [2:0] init_cmd;
  logic [scp_pkg::ADDR_W-1:0] init_addr;

  // Mode is loaded ahead of the refresh cycles, which the device accepts.
  always_comb
  begin
    st_d = st_q;
    wt_d = (wt_q != 16'h0000) ? wt_q - 16'h0001 : 16'h0000;
    init_cmd = scp_pkg::CMD_NOP;
    init_addr = '0;
    if (wt_q == 16'h0000)
    begin
      case (st_q)
        ST_POWER: st_d = ST_PREALL;
        ST_PREALL:
        begin
          init_cmd = scp_pkg::CMD_PRE;
          init_addr[scp_pkg::AP_BIT] = 1'b1;
          wt_d = 16'(scp_pkg::RP_CYC);
          st_d = ST_MODE;
        end
        ST_MODE:
        begin
          init_cmd = scp_pkg::CMD_MRS;
          init_addr = MODE_WORD;
          wt_d = 16'(scp_pkg::T_MRD_CYC);
          st_d = ST_REF_A;
        end
        ST_REF_A:
        begin
          init_cmd = scp_pkg::CMD_REF;
          wt_d = 16'(scp_pkg::RFC_CYC);
          st_d = ST_REF_B;
        end
        ST_REF_B:
        begin
          init_cmd = scp_pkg::CMD_REF;
          wt_d = 16'(scp_pkg::RFC_CYC);
          st_d = ST_RUN;
        end
        default: st_d = ST_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Request check
  // ****************************************************************
  logic [NB-1:0] open_w;
  logic [NB-1:0] ras_ok_w;
  logic [NB-1:0] rcd_ok_w;
  logic [NB-1:0] idle_ok_w;
  logic [NB-1:0] wrec_ok_w;
  logic [8:0] wleft_q;
  logic [8:0] rleft_q;
  logic [1:0] wbank_q;
  logic [CAS_LAT:0] rsh_q;

  wire logic [1:0] b = i_cmd_bank;
  wire logic run = (st_q == ST_RUN) & (wt_q == 16'h0000);
  wire logic op_act = (i_cmd_op == scp_pkg::OP_ACT);
  wire logic op_rd = (i_cmd_op == scp_pkg::OP_RD);
  wire logic op_wr = (i_cmd_op == scp_pkg::OP_WR);
  wire logic op_pre = (i_cmd_op == scp_pkg::OP_PRE);
  wire logic op_ok = (op_act & ~open_w[b] & idle_ok_w[b])
                     | ((op_rd | op_wr) & open_w[b] & rcd_ok_w[b])
                     | (op_pre & open_w[b] & ras_ok_w[b] & wrec_ok_w[b]);
  wire logic take = i_cmd_valid & run & ~o_cmd_taken & op_ok;
  wire logic colt = take & (op_rd | op_wr);
  wire logic wcont = (wleft_q != 9'h000) & ~colt;
  wire logic rbeat = (take & op_rd) | ((rleft_q != 9'h000) & ~colt);
  wire logic [8:0] wleft_d = (take & op_wr) ? 9'(BURST_LEN - 1)
                           : colt ? 9'h000
                           : wcont ? wleft_q - 9'h001 : wleft_q;
  wire logic [8:0] rleft_d = (take & op_rd) ? 9'(BURST_LEN - 1)
                           : colt ? 9'h000
                           : (rleft_q != 9'h000) ? rleft_q - 9'h001 : rleft_q;
  wire logic [2:0] run_cmd = op_act ? scp_pkg::CMD_ACT : op_rd ? scp_pkg::CMD_RD
                           : op_wr ? scp_pkg::CMD_WR : scp_pkg::CMD_PRE;
  logic [scp_pkg::ADDR_W-1:0] run_addr;

  always_comb
  begin
    run_addr = i_cmd_addr;
    if (op_rd || op_wr)
      run_addr[scp_pkg::AP_BIT] = i_cmd_ap;
    else if (op_pre)
      run_addr[scp_pkg::AP_BIT] = 1'b0;
  end

  // ****************************************************************
  // Per-bank timing guards
  // ****************************************************************
  for (genvar i = 0; i < NB; i++)
  begin : g_bank
    logic open_q;
    logic [5:0] ras_q, rcd_q, idle_q, wrec_q;
    wire logic hit = take & (b == 2'(i));
    wire logic ap_col = hit & (op_rd | op_wr) & i_cmd_ap;
    wire logic wbeat = (hit & op_wr) | (wcont & (wbank_q == 2'(i)));
    always_ff @(posedge i_ref_clk)
    begin
      if (i_sys_rst)
      begin
        open_q <= 1'b0;
        {ras_q, rcd_q, idle_q, wrec_q} <= '0;
      end
      else if (i_clk_en)
      begin
        open_q <= (hit & op_act) | (open_q & ~(hit & op_pre) & ~ap_col);
        ras_q <= (hit & op_act) ? 6'(scp_pkg::RAS_CYC) : ras_q - 6'(ras_q != 6'h00);
        rcd_q <= (hit & op_act) ? 6'(scp_pkg::RCD_CYC) : rcd_q - 6'(rcd_q != 6'h00);
        wrec_q <= wbeat ? 6'(scp_pkg::WR_CYC) : wrec_q - 6'(wrec_q != 6'h00);
        // Full burst length is assumed, so an early interrupt only adds margin.
        if (hit & op_pre)
          idle_q <= 6'(scp_pkg::RP_CYC);
        else if (ap_col)
          idle_q <= 6'(BURST_LEN + scp_pkg::RP_CYC + (op_wr ? scp_pkg::WR_CYC : 0));
        else if (idle_q != 6'h00)
          idle_q <= idle_q - 6'h01;
      end
    end
    assign open_w[i] = open_q;
    assign ras_ok_w[i] = (ras_q == 6'h00);
    assign rcd_ok_w[i] = (rcd_q == 6'h00);
    assign idle_ok_w[i] = (idle_q == 6'h00);
    assign wrec_ok_w[i] = (wrec_q == 6'h00);
  end

  // ****************************************************************
  // Pin and answer registers
  // ****************************************************************
  logic cs_n_q, dqm_q, dq_oe_q;
  logic [2:0] cmd_q;
  logic [1:0] ba_q;
  logic [scp_pkg::ADDR_W-1:0] addr_q;
  logic [scp_pkg::DQ_W-1:0] dq_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      st_q <= ST_POWER;
      wt_q <= 16'(INIT_CYC);
      {cs_n_q, cmd_q} <= {1'b1, scp_pkg::CMD_NOP};
      {ba_q, addr_q, dq_q, dq_oe_q, dqm_q} <= '0;
      {wleft_q, rleft_q, wbank_q, rsh_q} <= '0;
      {o_cmd_taken, o_wbeat, o_rdata, o_rdata_valid, o_init_done} <= '0;
    end
    else if (i_clk_en)
    begin
      st_q <= st_d;
      wt_q <= wt_d;
      cs_n_q <= ~(take | (init_cmd != scp_pkg::CMD_NOP));
      cmd_q <= take ? run_cmd : init_cmd;
      ba_q <= take ? b : ba_q;
      addr_q <= take ? run_addr : init_addr;
      // A read stops the data drive, so its own edge carries nothing.
      dq_oe_q <= (take & op_wr) | wcont;
      dq_q <= i_wdata;
      dqm_q <= ((take & op_wr) | wcont) & i_wmask;
      wleft_q <= wleft_d;
      rleft_q <= rleft_d;
      wbank_q <= (take & op_wr) ? b : wbank_q;
      rsh_q <= {rsh_q[CAS_LAT-1:0], rbeat};
      o_cmd_taken <= take;
      o_wbeat <= (wleft_d != 9'h000);
      o_rdata_valid <= rsh_q[CAS_LAT];
      o_rdata <= pins.dq;
      o_init_done <= (st_d == ST_RUN) & (wt_d == 16'h0000);
    end
  end

  assign pins.cs_n = cs_n_q;
  assign {pins.ras_n, pins.cas_n, pins.we_n} = cmd_q;
  assign pins.ba = ba_q;
  assign pins.addr = addr_q;
  assign pins.dqm = dqm_q;
  assign pins.ctl_dq_o = dq_q;
  assign pins.ctl_dq_oe = dq_oe_q;
endmodule

// file: tb/scp_link_props.sv
// Checker for the pins between the SDRAM device end and the controller end.
module scp_link_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [scp_pkg::BANK_W-1:0] ba,
  input wire logic [scp_pkg::ADDR_W-1:0] addr,
  // Data enables
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  logic [2:0] cmd;
  logic rd;
  logic wr;
  logic act;
  logic [3:0] age_q;
  logic [scp_pkg::BANK_W-1:0] apb_q;
  logic pre;
  logic [3:0] act_age_q;
  logic [scp_pkg::BANK_W-1:0] actb_q;
  assign cmd = {ras_n, cas_n, we_n};
  assign rd = !cs_n && cmd == scp_pkg::CMD_RD;
  assign wr = !cs_n && cmd == scp_pkg::CMD_WR;
  assign act = !cs_n && cmd == scp_pkg::CMD_ACT;
  assign pre = !cs_n && cmd == scp_pkg::CMD_PRE && !addr[scp_pkg::AP_BIT];
  // Only the latest activate is aged, so a precharge to an older bank goes unchecked.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      act_age_q <= 4'hf;
    else if (act)
      act_age_q <= 4'h0;
    else if (act_age_q != 4'hf)
      act_age_q <= act_age_q + 4'h1;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (act)
      actb_q <= ba;
  end
  // Only the latest auto precharge write is tracked; the bench runs one at a time.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      age_q <= 4'hf;
    else if (wr && addr[scp_pkg::AP_BIT])
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (wr && addr[scp_pkg::AP_BIT])
      apb_q <= ba;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_rd_data_lat: assert property (rd ##1 (!wr)[*2] |-> ##1 dev_dq_oe)
    else $error("read data not driven at latency");
  chk_no_bus_clash: assert property (!(ctl_dq_oe && dev_dq_oe))
    else $error("both ends drive data");
  chk_oe_needs_rd: assert property ($rose(dev_dq_oe) |-> $past(rd, 3))
    else $error("device drove data without a selected read");
  chk_rd_burst_len: assert property ($rose(dev_dq_oe) |=> dev_dq_oe[*3])
    else $error("read burst shorter than four words");
  chk_wr_data_drv: assert property (wr |-> ctl_dq_oe)
    else $error("write data missing on command edge");
  chk_ctl_oe_start: assert property ($rose(ctl_dq_oe) |-> wr)
    else $error("controller drove data without a write");
  chk_wr_burst_end: assert property (wr ##1 (!wr)[*3] |-> ##1 !ctl_dq_oe)
    else $error("write data driven past burst");
  chk_act_ap_gap: assert property (act && ba == apb_q |-> age_q >= 4'h7)
    else $error("bank activated during pending auto precharge");
  chk_pre_ras_gap: assert property (pre && ba == actb_q
    |-> act_age_q >= 4'(scp_pkg::RAS_CYC - 1))
    else $error("bank precharged before row-active time");
endmodule

// file: tb/sdram_concurrent_auto_precharge_tb_top.sv
// Self-checking bench for the concurrent auto precharge SDRAM pair.
`define CHK(nm, e, g) \
  begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module sdram_concurrent_auto_precharge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  scp_pkg::scp_op_e op = scp_pkg::OP_ACT;
  logic [1:0] bnk = 2'h0;
  logic [11:0] adr = 12'h000;
  logic ap = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic taken, wbeat, rvld, idone;
  logic [15:0] rdat;
  logic [3:0] bopen, apnd;
  logic [15:0] w [4];
  int fail_count = 0;
  int comparisons = 0;
  scp_if u_scp_if ();
  scp_sdram_dev u_scp_sdram_dev (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
    .pins(u_scp_if), .o_bank_open(bopen), .o_ap_pending(apnd));
  scp_sdram_ctl #(.INIT_CYC(10)) u_scp_sdram_ctl (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_clk_en(1'b1), .pins(u_scp_if), .i_cmd_valid(vld), .i_cmd_op(op), .i_cmd_bank(bnk),
    .i_cmd_addr(adr), .i_cmd_ap(ap), .i_wdata(wd), .i_wmask(1'b0), .o_cmd_taken(taken),
    .o_wbeat(wbeat), .o_rdata(rdat), .o_rdata_valid(rvld), .o_init_done(idone));
  scp_link_props u_scp_link_props (.i_ref_clk(clk), .i_sys_rst(rst), .cs_n(u_scp_if.cs_n),
    .ras_n(u_scp_if.ras_n), .cas_n(u_scp_if.cas_n), .we_n(u_scp_if.we_n), .ba(u_scp_if.ba),
    .addr(u_scp_if.addr), .ctl_dq_oe(u_scp_if.ctl_dq_oe), .dev_dq_oe(u_scp_if.dev_dq_oe));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Each consumed beat advances the data, so stored words show which edge took them.
  always @(negedge clk)
    if (taken === 1'b1 || wbeat === 1'b1)
      wd <= wd + 16'h0001;
  task automatic wrap_up;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic req(input scp_pkg::scp_op_e o, input logic [1:0] b, input logic [11:0] a,
    input logic p);
    int n;
    op = o;
    bnk = b;
    adr = a;
    ap = p;
    vld = 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (taken !== 1'b1 && n < 200);
    vld = 1'b0;
    if (taken !== 1'b1)
    begin
      `CHK("request taken", 1'b1, taken)
      wrap_up();
    end
    // One edge passes with valid low, so a following request never retoggles it in one step.
    @(negedge clk);
  endtask
  task automatic grab(input logic [1:0] b, input logic [11:0] a);
    int n;
    int k;
    req(scp_pkg::OP_RD, b, a, 1'b0);
    k = 0;
    for (n = 0; n < 20 && k < 4; n++)
    begin
      @(negedge clk);
      if (rvld === 1'b1)
      begin
        w[k] = rdat;
        k++;
      end
    end
    `CHK("read words", 4, k)
    if (k != 4)
      wrap_up();
  endtask
  task automatic t_init;
    int n;
    for (n = 0; n < 400 && idone !== 1'b1; n++)
      @(negedge clk);
    `CHK("init done", 1'b1, idone)
    if (idone !== 1'b1)
      wrap_up();
    req(scp_pkg::OP_ACT, 2'h0, 12'h005, 1'b0);
    req(scp_pkg::OP_ACT, 2'h1, 12'h006, 1'b0);
    @(negedge clk);
    `CHK("banks open", 4'h3, bopen)
    $display("test init done");
  endtask
  task automatic t_rd_wr;
    wd = 16'h1a00;
    req(scp_pkg::OP_WR, 2'h0, 12'hb00, 1'b1);
    req(scp_pkg::OP_RD, 2'h1, 12'h000, 1'b0);
    @(negedge clk);
    `CHK("pending after read", 1'b1, apnd[0])
    repeat (8) @(negedge clk);
    `CHK("pending over", 1'b0, apnd[0])
    `CHK("row closed", 1'b0, bopen[0])
    req(scp_pkg::OP_ACT, 2'h0, 12'h005, 1'b0);
    grab(2'h0, 12'h000);
    `CHK("first word", 16'h1a00, w[0])
    `CHK("last word kept", 16'h1a01, w[1])
    `CHK("cut word dropped", 1'b1, w[2] !== 16'h1a02)
    $display("test read cuts write done");
  endtask
  task automatic t_wr_wr;
    wd = 16'h2b00;
    req(scp_pkg::OP_WR, 2'h0, 12'h004, 1'b1);
    req(scp_pkg::OP_WR, 2'h1, 12'h000, 1'b0);
    @(negedge clk);
    `CHK("pending after write", 1'b1, apnd[0])
    repeat (8) @(negedge clk);
    `CHK("pending ended", 1'b0, apnd[0])
    `CHK("row shut", 1'b0, bopen[0])
    req(scp_pkg::OP_ACT, 2'h0, 12'h005, 1'b0);
    grab(2'h0, 12'h004);
    `CHK("old bank word", 16'h2b01, w[1])
    `CHK("old bank cut", 1'b1, w[2] !== 16'h2b02)
    grab(2'h1, 12'h000);
    `CHK("new bank word", 16'h2b02, w[0])
    $display("test write cuts write done");
  endtask
  task automatic t_pre;
    req(scp_pkg::OP_PRE, 2'h1, 12'h000, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("bank precharged", 1'b0, bopen[1])
    req(scp_pkg::OP_ACT, 2'h1, 12'h006, 1'b0);
    req(scp_pkg::OP_PRE, 2'h1, 12'h000, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("reopened bank precharged", 1'b0, bopen[1])
    $display("test precharge done");
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_init();
    t_rd_wr();
    t_wr_wr();
    t_pre();
    wrap_up();
  end
endmodule
